//--- design/mmt_map.svh
// Register map and field constants of the memory mapping table.
// Assumes a 12-bit AXI4-Lite byte address and 32-bit data words.
`ifndef MMT_MAP_SVH
`define MMT_MAP_SVH

// Mapping entries sit one per 64-byte stride from the first to the last.
`define MMT_MAP_FIRST 12'h200
`define MMT_MAP_LAST 12'h3c0
`define MMT_MAP_IDX_LO 6
`define MMT_LOOKUP_STATUS 12'h400

// Entries start cleared, so no slot claims any address until loaded.
`define MMT_ENTRY_RESET 32'h0000_0000
// Bits 16 to 11 are never stored.
`define MMT_ENTRY_WMASK 32'hfffe_07ff

// Byte-address bits that the base field compares against.
`define MMT_BASE_ADDR_HI 39
`define MMT_BASE_ADDR_LO 25
`define MMT_BASE_BITS 15

// Interleave code that is reserved.
`define MMT_ILV_RESERVED 2'b11

// Lowest address bit used for interleave and bank selection.
`define MMT_LINE_LO 6

// AXI responses.
`define MMT_RESP_OKAY 2'b00
`define MMT_RESP_SLVERR 2'b10

`endif

//--- design/mmt_pkg.sv
// Types shared by the memory mapping table modules.
// Assumes the field layout of one 32-bit mapping entry.
package mmt_pkg;

	// One mapping entry, most significant field first.
	typedef struct packed {
		logic [14:0] base;
		logic [5:0] unused_bits;
		logic [1:0] bank_count_code;
		logic [3:0] base_match_width;
		logic [1:0] ilv_pos;
		logic [1:0] ilv_code;
		logic present;
	} mmt_entry_t;

	// Outcome of one address lookup.
	typedef struct packed {
		logic multi_hit;
		logic hit;
		logic [2:0] node;
		logic [2:0] bank;
	} mmt_result_t;

endpackage

//--- design/mmt_entry_match.sv
// Address comparator for one mapping entry.
// Assumes a stable entry and a 40-bit byte address on the same clock.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_map.svh"

module mmt_entry_match
#(
	parameter int LINE_LO = `MMT_LINE_LO
)
(
	input wire mmt_pkg::mmt_entry_t entry,
	input wire logic [39:0] addr,
	output logic hit,
	output logic [2:0] bank
);
	import mmt_pkg::*;

	logic [14:0] width_mask;
	logic [14:0] base_diff;
	logic base_ok;
	logic ilv_ok;
	logic [5:0] low_bits;
	logic [5:0] bank_window;
	logic [2:0] bank_mask;

	// Only the top base_match_width base bits take part in the match.
	genvar i;
	generate
		for (i = 0; i < `MMT_BASE_BITS; i++)
		begin : g_mask
			assign width_mask[i] = (5'(i) + {1'b0, entry.base_match_width}) >= 5'd15;
		end
	endgenerate

	// Base compare against byte-address bits 39 to 25.
	assign base_diff = addr[`MMT_BASE_ADDR_HI:`MMT_BASE_ADDR_LO] ^ entry.base;
	assign base_ok = (base_diff & width_mask) == 15'h0000;

	// Interleave compares 0, 1 or 2 low address bits; the reserved code never matches.
	assign low_bits = addr[LINE_LO +: 6];
	assign ilv_ok = (entry.ilv_code == 2'b00) ||
		(entry.ilv_code == 2'b01 && low_bits[0] == entry.ilv_pos[0]) ||
		(entry.ilv_code == 2'b10 && low_bits[1:0] == entry.ilv_pos);

	// Bank number takes 0 to 3 bits just above the interleave bits.
	assign bank_window = low_bits >> entry.ilv_code;
	assign bank_mask = 3'b111 >> (2'd3 - entry.bank_count_code);
	assign bank = bank_window[2:0] & bank_mask;

	// A slot claims the address only when installed and both compares pass.
	assign hit = entry.present && base_ok && ilv_ok;

endmodule
`default_nettype wire

//--- design/mmt_axil_slave.sv
// AXI4-Lite slave front end with one write and one read under way.
// Assumes the core answers read data and errors combinationally.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_map.svh"

module mmt_axil_slave
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [11:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output logic wr_go,
	output logic [11:0] wr_addr,
	output logic [31:0] wr_data,
	output logic [3:0] wr_strb,
	input wire logic wr_err,
	output logic rd_fire,
	input wire logic [31:0] rd_data,
	input wire logic rd_err
);
	logic aw_held;
	logic w_held;

	// Address and data are caught in either order; the write fires once both are held.
	assign s_axil_awready = !aw_held && !s_axil_bvalid;
	assign s_axil_wready = !w_held && !s_axil_bvalid;
	assign wr_go = aw_held && w_held && !s_axil_bvalid;
	assign s_axil_arready = !s_axil_rvalid;
	assign rd_fire = s_axil_arvalid && s_axil_arready;

	// Write channel capture and response.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 12'h000;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			s_axil_bvalid <= 1'b0;
			s_axil_bresp <= `MMT_RESP_OKAY;
		end
		else
		begin
			if (s_axil_awvalid && s_axil_awready)
			begin
				aw_held <= 1'b1;
				wr_addr <= s_axil_awaddr;
			end
			if (s_axil_wvalid && s_axil_wready)
			begin
				w_held <= 1'b1;
				wr_data <= s_axil_wdata;
				wr_strb <= s_axil_wstrb;
			end
			if (wr_go)
			begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axil_bvalid <= 1'b1;
				s_axil_bresp <= wr_err ? `MMT_RESP_SLVERR : `MMT_RESP_OKAY;
			end
			else if (s_axil_bready)
				s_axil_bvalid <= 1'b0;
		end
	end

	// Read data are registered at the same edge that takes the address.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axil_rvalid <= 1'b0;
			s_axil_rdata <= 32'h0000_0000;
			s_axil_rresp <= `MMT_RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axil_rvalid <= 1'b1;
			s_axil_rdata <= rd_data;
			s_axil_rresp <= rd_err ? `MMT_RESP_SLVERR : `MMT_RESP_OKAY;
		end
		else if (s_axil_rready)
			s_axil_rvalid <= 1'b0;
	end

endmodule
`default_nettype wire

//--- design/mmt_top.sv
// Memory mapping table: eight node-slot entries and the address lookup built on them.
// Assumes lookup requests come from logic on aclk and software loads entries over AXI4-Lite.
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_map.svh"

module mmt_top
#(
	parameter int LINE_LO = `MMT_LINE_LO
)
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [11:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [11:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic lookup_valid,
	input wire logic [39:0] lookup_addr,
	output logic lookup_done,
	output mmt_pkg::mmt_result_t lookup_result,
	output logic [7:0] lookup_hits
);
	import mmt_pkg::*;

	mmt_entry_t [7:0] map_q;
	logic wr_go;
	logic [11:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic rd_fire;
	logic [31:0] rd_data;
	logic rd_err;
	logic wr_err;

	// Write address decode: entries are one per stride, indexed by address bits 8 to 6.
	logic [11:0] wr_off;
	logic wr_is_map;
	logic [2:0] wr_idx;
	logic [31:0] wr_lanes;
	assign wr_off = wr_addr - `MMT_MAP_FIRST;
	assign wr_is_map = wr_addr >= `MMT_MAP_FIRST && wr_addr <= `MMT_MAP_LAST && wr_off[5:0] == 6'h00;
	assign wr_idx = wr_off[`MMT_MAP_IDX_LO +: 3];
	assign wr_err = !wr_is_map;
	assign wr_lanes = {{8{wr_strb[3]}}, {8{wr_strb[2]}}, {8{wr_strb[1]}}, {8{wr_strb[0]}}};

	// Read address decode, with the lookup status word beside the entries.
	logic [11:0] rd_off;
	logic rd_is_map;
	logic rd_is_status;
	logic [2:0] rd_idx;
	assign rd_off = s_axil_araddr - `MMT_MAP_FIRST;
	assign rd_is_map = s_axil_araddr >= `MMT_MAP_FIRST && s_axil_araddr <= `MMT_MAP_LAST &&
		rd_off[5:0] == 6'h00;
	assign rd_is_status = s_axil_araddr == `MMT_LOOKUP_STATUS;
	assign rd_idx = rd_off[`MMT_MAP_IDX_LO +: 3];
	assign rd_err = !rd_is_map && !rd_is_status;

	// Read data mux; unused bits are never stored, so they read back as zero.
	assign rd_data = rd_is_map ? 32'(map_q[rd_idx]) :
		rd_is_status ? 32'(lookup_result) : 32'h0000_0000;

	// Entry storage; each slot copies the module map that software writes into it.
	// Reset leaves every slot absent until initialisation loads it.
	genvar k;
	generate
		for (k = 0; k < 8; k++)
		begin : g_entry
			logic [31:0] next_entry;
			assign next_entry = ((32'(map_q[k]) & ~wr_lanes) | (wr_data & wr_lanes)) & `MMT_ENTRY_WMASK;

			always_ff @(posedge aclk)
			begin
				if (!aresetn)
					map_q[k] <= mmt_entry_t'(`MMT_ENTRY_RESET);
				else if (wr_go && wr_is_map && wr_idx == 3'(k))
					map_q[k] <= mmt_entry_t'(next_entry);
			end
		end
	endgenerate

	// One comparator per node slot.
	logic [7:0] hit_vec;
	logic [2:0] bank_vec [8];
	generate
		for (k = 0; k < 8; k++)
		begin : g_match
			mmt_entry_match #(
				.LINE_LO(LINE_LO)
			) u_match (
				.entry(map_q[k]),
				.addr(lookup_addr),
				.hit(hit_vec[k]),
				.bank(bank_vec[k])
			);
		end
	endgenerate

	// Lowest hitting node wins; more than one hit shows an overlapping map.
	logic [2:0] win_node;
	logic multi;
	always_comb
	begin
		win_node = 3'd0;
		for (int n = 7; n >= 0; n--)
		begin
			if (hit_vec[n])
				win_node = 3'(n);
		end
	end
	assign multi = (hit_vec & (hit_vec - 8'h01)) != 8'h00;

	// Lookup answer, one cycle after the request.
	mmt_result_t next_result;
	assign next_result.multi_hit = multi;
	assign next_result.hit = hit_vec != 8'h00;
	assign next_result.node = win_node;
	assign next_result.bank = hit_vec != 8'h00 ? bank_vec[win_node] : 3'd0;

	// The result also stands as the readable status word until the next lookup.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lookup_done <= 1'b0;
			lookup_result <= '0;
			lookup_hits <= 8'h00;
		end
		else
		begin
			lookup_done <= lookup_valid;
			if (lookup_valid)
			begin
				lookup_result <= next_result;
				lookup_hits <= hit_vec;
			end
		end
	end

	// Register bus front end.
	mmt_axil_slave u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.wr_go(wr_go),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_fire(rd_fire),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Helper copies of the lookup inputs and the map one cycle back.
	logic [39:0] prev_addr;
	mmt_entry_t [7:0] prev_map;
	always_ff @(posedge aclk)
	begin
		prev_addr <= lookup_addr;
		prev_map <= map_q;
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Unused bits stay zero in every slot.
	generate
		for (k = 0; k < 8; k++)
		begin : g_chk
			a_unused_bits_zero: assert property (map_q[k].unused_bits == 6'h00)
				else $error("unused bits of a mapping entry are not zero");
		end
	endgenerate

	// A full-word write to a slot lands, masked, in exactly that slot.
	a_write_lands_slot: assert property (wr_go && wr_is_map && wr_strb == 4'hf |=>
		32'(map_q[$past(wr_idx)]) == ($past(wr_data) & `MMT_ENTRY_WMASK))
		else $error("mapping write did not land in its slot");

	// Each request gives exactly one done pulse the next cycle.
	sequence s_lookup_req;
		lookup_valid;
	endsequence
	sequence s_lookup_ans;
		lookup_done ##1 (!lookup_done || $past(lookup_valid));
	endsequence
	a_lookup_one_cycle: assert property (s_lookup_req |=> s_lookup_ans)
		else $error("lookup answer missing or stretched");

	a_lookup_no_spurious: assert property (!lookup_valid |=> !lookup_done)
		else $error("lookup done without a request");

	// A reported hit always belongs to an installed slot using a legal interleave code.
	a_hit_present: assert property (lookup_done && lookup_result.hit |->
		prev_map[lookup_result.node].present && lookup_hits[lookup_result.node])
		else $error("hit reported for an absent slot");

	a_hit_no_reserved: assert property (lookup_done && lookup_result.hit |->
		prev_map[lookup_result.node].ilv_code != `MMT_ILV_RESERVED)
		else $error("hit through the reserved interleave code");

	// With full width every base bit must equal the address bits.
	a_full_width_base: assert property (lookup_done && lookup_result.hit &&
		prev_map[lookup_result.node].base_match_width == 4'hf |->
		prev_addr[`MMT_BASE_ADDR_HI:`MMT_BASE_ADDR_LO] == prev_map[lookup_result.node].base)
		else $error("full-width base mismatch on a hit");

	// Two-way interleave checks the lowest selection bit against the position.
	a_ilv_two_way: assert property (lookup_done && lookup_result.hit &&
		prev_map[lookup_result.node].ilv_code == 2'b01 |->
		prev_addr[LINE_LO] == prev_map[lookup_result.node].ilv_pos[0])
		else $error("interleave position mismatch on a hit");

	// The bank number never uses more bits than the bank count allows.
	a_bank_width: assert property (lookup_done && lookup_result.hit |->
		(lookup_result.bank >> prev_map[lookup_result.node].bank_count_code) == 3'd0)
		else $error("bank number wider than the bank count");

	// A taken write answers within two cycles; a taken read answers the next cycle.
	a_write_answer: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid &&
		s_axil_wready |-> ##[1:2] s_axil_bvalid)
		else $error("write response late");

	a_read_answer: assert property (rd_fire |=> s_axil_rvalid)
		else $error("read response late");

endmodule
`default_nettype wire

//--- tb/mmt_cmd_src.sv
// Command-cycle source standing at the far side of the lookup port.
// Assumes the bench raises go one cycle ahead of each request it wants issued.
`timescale 1ns/1ps
`default_nettype none

module mmt_cmd_src
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [39:0] addr,
	output logic lookup_valid,
	output logic [39:0] lookup_addr
);
	// Issue one request a cycle after go; idle address lines wander so stale values never match by luck.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			lookup_valid <= 1'b0;
			lookup_addr <= 40'h0;
		end
		else
		begin
			lookup_valid <= go;
			lookup_addr <= go ? addr : ~lookup_addr;
		end
	end
endmodule

`default_nettype wire

//--- tb/memory_map_table_tb.sv
// Self-checking bench for the memory mapping table.
// Assumes the design files and mmt_map.svh are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "mmt_map.svh"

module memory_map_table_tb;
	import mmt_pkg::*;
	localparam int LINE_LO = `MMT_LINE_LO;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [11:0] awaddr = 12'h0;
	logic awvalid = 1'b0;
	logic awready;
	logic [31:0] wdata = 32'h0;
	logic [3:0] wstrb = 4'h0;
	logic wvalid = 1'b0;
	logic wready;
	logic [1:0] bresp;
	logic bvalid;
	logic bready = 1'b1;
	logic [11:0] araddr = 12'h0;
	logic arvalid = 1'b0;
	logic arready;
	logic [31:0] rdata;
	logic [1:0] rresp;
	logic rvalid;
	logic rready = 1'b1;
	logic go = 1'b0;
	logic [39:0] ga = 40'h0;
	logic lv;
	logic [39:0] la;
	logic done;
	mmt_result_t res;
	logic [7:0] hits;
	logic [31:0] shadow [8];
	int error_cnt = 0;
	int n_tests = 0;

	// The clock toggles every 2 ns, half of its 4 ns period.
	always #2 aclk = ~aclk;

	mmt_top #(.LINE_LO(LINE_LO)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
		.s_axil_wdata(wdata), .s_axil_wstrb(wstrb), .s_axil_wvalid(wvalid), .s_axil_wready(wready),
		.s_axil_bresp(bresp), .s_axil_bvalid(bvalid), .s_axil_bready(bready),
		.s_axil_araddr(araddr), .s_axil_arvalid(arvalid), .s_axil_arready(arready),
		.s_axil_rdata(rdata), .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
		.lookup_valid(lv), .lookup_addr(la), .lookup_done(done), .lookup_result(res), .lookup_hits(hits));

	mmt_cmd_src i_src (.aclk(aclk), .aresetn(aresetn), .go(go), .addr(ga), .lookup_valid(lv), .lookup_addr(la));

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out;
		$display("Checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// One AXI4-Lite write; each channel is released at the edge that takes it.
	task automatic axw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
		int k;
		k = 0;
		r = 2'b11;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (k < 100)
		begin
			@(posedge aclk);
			k++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
			if (bvalid)
			begin
				r = bresp;
				k = 200;
			end
		end
		chk("wr_answer", k, 200);
	endtask

	// One AXI4-Lite read; data are taken at the edge where rvalid is seen.
	task automatic axr(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		k = 0;
		d = 32'h0;
		r = 2'b11;
		araddr <= a;
		arvalid <= 1'b1;
		while (k < 100)
		begin
			@(posedge aclk);
			k++;
			if (arready)
				arvalid <= 1'b0;
			if (rvalid)
			begin
				d = rdata;
				r = rresp;
				k = 200;
			end
		end
		chk("rd_answer", k, 200);
	endtask

	// Works out hit vector and result of a lookup from the shadow map; lowest node wins.
	function automatic logic [15:0] model(input logic [39:0] a);
		mmt_entry_t e;
		logic [7:0] h;
		logic [7:0] r;
		logic [14:0] m;
		int k;
		h = 8'h0;
		r = 8'h0;
		for (int n = 7; n >= 0; n--)
		begin
			e = mmt_entry_t'(shadow[n]);
			m = ~(15'h7fff >> e.base_match_width);
			k = e.ilv_code;
			if (e.present && k != 3 && ((a[39:25] ^ e.base) & m) == 15'h0
				&& (((a >> LINE_LO) ^ 40'(e.ilv_pos)) & ((40'h1 << k) - 40'h1)) == 40'h0)
			begin
				h[n] = 1'b1;
				r[5:3] = 3'(n);
				r[2:0] = 3'((a >> (LINE_LO + k)) & ((40'h1 << e.bank_count_code) - 40'h1));
			end
		end
		r[6] = |h;
		r[7] = $countones(h) > 1;
		return {h, r};
	endfunction

	// Asks the far-side source for one lookup and checks the answer a cycle after it is taken.
	task automatic look(input logic [39:0] a);
		logic [15:0] e;
		e = model(a);
		go <= 1'b1;
		ga <= a;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		chk("done", done, 1);
		chk("hits", hits, e[15:8]);
		if (e[6])
			chk("result", res, e[7:0]);
		else
			chk("miss", res[7:6], 2'b00);
		@(posedge aclk);
	endtask

	// Main sequence: reset, reset values, random loads with read-back and lookups, unmapped places.
	initial
	begin
		logic [31:0] d;
		logic [31:0] x;
		logic [1:0] r;
		logic [3:0] s;
		logic [39:0] a;
		int seed;
		seed = 32'hefbc;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		for (int n = 0; n < 8; n++)
		begin
			shadow[n] = `MMT_ENTRY_RESET;
			axr(12'h200 + 12'(n * 64), d, r);
			chk("reset_val", d, 32'h0);
		end
		look({8'($random(seed)), 32'($random(seed))});
		repeat (20)
		begin
			for (int n = 0; n < 8; n++)
			begin
				d = $random(seed);
				s = (n == 0) ? 4'hf : 4'($random(seed));
				axw(12'h200 + 12'(n * 64), d, s, r);
				chk("wr_resp", r, `MMT_RESP_OKAY);
				for (int b = 0; b < 4; b++)
					if (s[b])
						shadow[n][8*b +: 8] = d[8*b +: 8];
				shadow[n] = shadow[n] & `MMT_ENTRY_WMASK;
			end
			for (int n = 0; n < 8; n++)
			begin
				axr(12'h200 + 12'(n * 64), d, r);
				chk("readback", d, shadow[n]);
				chk("rd_resp", r, `MMT_RESP_OKAY);
			end
			repeat (16)
			begin
				x = shadow[$unsigned($random(seed)) % 8];
				a = {x[31:17], 25'($random(seed))};
				look(a);
			end
		end
		// Two lookups on consecutive cycles; the second answer stands one cycle after the first.
		a = {shadow[1][31:17], 25'($random(seed))};
		x = 32'(model(a));
		go <= 1'b1;
		ga <= ~a;
		@(posedge aclk);
		ga <= a;
		@(posedge aclk);
		go <= 1'b0;
		@(posedge aclk);
		#1;
		chk("b2b_done", done, 1);
		chk("b2b_hits", hits, x[15:8]);
		@(posedge aclk);
		axw(12'h100, 32'hffff_ffff, 4'hf, r);
		chk("unmapped_wr", r, `MMT_RESP_SLVERR);
		axr(12'h7fc, d, r);
		chk("unmapped_rresp", r, `MMT_RESP_SLVERR);
		chk("unmapped_rdata", d, 32'h0);
		// The status word still shows the answer of the last lookup.
		axr(`MMT_LOOKUP_STATUS, d, r);
		chk("status", d, {24'h0, x[7:0]});
		close_out();
	end

	// Cuts a hang short well beyond the roughly two thousand cycles the sequence needs.
	initial
	begin
		repeat (20000) @(posedge aclk);
		error_cnt++;
		close_out();
	end
endmodule

`default_nettype wire
